// ==== hdl/ugi_global_irq.sv ====
// What this block does
// - host config, alternate or interface value request sets flag bit 7.
// - bit 7 never clears itself; written zero clears, written one is ignored.
// - request-value flag interrupts only while its enable at E6 is set.
// - bits 6 and 5 are reserved, read as zero, software writes zeros.
// - bits 4 to 0 show pending requests of endpoints 4 to 0.
// - endpoint pending interrupts only with bit 4 of its buffer control set.
// - endpoint interrupt needs CPU master and USB endpoint enables set.
// - device registers appear only while selector at D2 holds 80.
// - pending flag sets when any of its eight endpoint requests rises.
// - pending flag clears when CPU reads that endpoint's request register.
`timescale 1ns/1ns
module ugi_global_irq
#(
    parameter int NUM_EP = ugi_pkg::NUM_EP,
    parameter int REQS_PER_EP = ugi_pkg::REQS_PER_EP
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_master_irq_enable,
    input wire logic usb_endpoint_cpu_irq_enable,
    input wire logic [NUM_EP*REQS_PER_EP-1:0] endpoint_requests,
    input wire logic request_value_event,
    output logic usb_irq
);
    logic [7:0] usb_register_set_select;
    logic [NUM_EP-1:0] endpoint_global_irq_enable;
    logic request_value_irq_enable;
    logic [NUM_EP-1:0] endpoint_pending;
    logic request_value_irq_flag;
    logic [NUM_EP*REQS_PER_EP-1:0] requests_prev;
    logic [NUM_EP*REQS_PER_EP-1:0] requests_rise;
    logic [NUM_EP-1:0] ep_set;
    logic [NUM_EP-1:0] ep_read_clear;
    logic [NUM_EP-1:0] gie_write;
    logic device_set_selected;
    logic endpoint_set_selected;
    logic [NUM_EP-1:0] selected_ep;
    logic [7:0] global_flags_view;
    logic [7:0] selected_requests;
    logic [7:0] next_rdata;
    logic rv_clear;
    logic ep_irq_path;
    logic rv_irq_path;
    logic next_usb_irq;

    function automatic logic [NUM_EP-1:0] ep_onehot(input logic [7:0] sel);
        logic [NUM_EP-1:0] hot;
        hot = '0;
        for (int i = 0; i < NUM_EP; i++)
        begin
            if (!sel[ugi_pkg::BIT_SET_KIND] && sel[2:0] == i[2:0])
                hot[i] = 1'b1;
        end
        return hot;
    endfunction : ep_onehot

    // register set selection
    assign device_set_selected =
        usb_register_set_select == ugi_pkg::DEVICE_SET_VALUE;
    assign selected_ep = ep_onehot(usb_register_set_select);
    assign endpoint_set_selected = |selected_ep;

    // endpoint request edges
    assign requests_rise = endpoint_requests & ~requests_prev;

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            assign ep_set[g] =
                |requests_rise[g*REQS_PER_EP +: REQS_PER_EP];
        end
    endgenerate

    assign ep_read_clear = (sfr_rd && sfr_addr == ugi_pkg::ADDR_EP_IRQ_REQ)
        ? selected_ep : '0;
    assign gie_write = (sfr_wr && sfr_addr == ugi_pkg::ADDR_BUF_CONTROL)
        ? selected_ep : '0;

    // only a written zero clears the request-value flag
    assign rv_clear = sfr_wr && sfr_addr == ugi_pkg::ADDR_GLOBAL_FLAGS
        && !sfr_wdata[ugi_pkg::BIT_REQ_VALUE_FLAG];

    ugi_sticky_flags
    #(
        .WIDTH(NUM_EP)
    )
    u_ep_flags
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .set(ep_set),
        .clr(ep_read_clear),
        .flags(endpoint_pending)
    );

    ugi_sticky_flags
    #(
        .WIDTH(1)
    )
    u_rv_flag
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .set(request_value_event),
        .clr(rv_clear),
        .flags(request_value_irq_flag)
    );

    // read view
    always_comb
    begin
        global_flags_view = ugi_pkg::RST_GLOBAL_FLAGS;
        global_flags_view[ugi_pkg::BIT_REQ_VALUE_FLAG] =
            request_value_irq_flag;
        global_flags_view[NUM_EP-1:0] = endpoint_pending;
    end

    always_comb
    begin
        selected_requests = 8'h00;
        for (int i = 0; i < NUM_EP; i++)
        begin
            if (selected_ep[i])
                selected_requests =
                    8'(endpoint_requests[i*REQS_PER_EP +: REQS_PER_EP]);
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        case (sfr_addr)
            ugi_pkg::ADDR_SET_SELECT:
                next_rdata = usb_register_set_select;
            ugi_pkg::ADDR_GLOBAL_FLAGS:
                next_rdata = global_flags_view;
            ugi_pkg::ADDR_POWER_DOWN:
                next_rdata[ugi_pkg::BIT_REQ_VALUE_ENABLE] =
                    request_value_irq_enable;
            ugi_pkg::ADDR_BUF_CONTROL:
                next_rdata[ugi_pkg::BIT_EP_GLOBAL_IRQ_ENABLE] =
                    |(endpoint_global_irq_enable & selected_ep);
            ugi_pkg::ADDR_EP_IRQ_REQ:
                next_rdata = endpoint_set_selected
                    ? selected_requests : 8'h00;
            default:
                next_rdata = 8'h00;
        endcase
    end

    // interrupt line
    assign ep_irq_path = |(endpoint_pending & endpoint_global_irq_enable)
        && cpu_master_irq_enable && usb_endpoint_cpu_irq_enable;
    assign rv_irq_path = request_value_irq_flag && request_value_irq_enable
        && cpu_master_irq_enable;
    assign next_usb_irq = ep_irq_path || rv_irq_path;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            usb_register_set_select <= ugi_pkg::RST_SET_SELECT;
        else if (sfr_wr && sfr_addr == ugi_pkg::ADDR_SET_SELECT)
            usb_register_set_select <= sfr_wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            request_value_irq_enable <= ugi_pkg::RST_REQ_VALUE_ENABLE;
        else if (sfr_wr && sfr_addr == ugi_pkg::ADDR_POWER_DOWN)
            request_value_irq_enable <=
                sfr_wdata[ugi_pkg::BIT_REQ_VALUE_ENABLE];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            endpoint_global_irq_enable <= {NUM_EP{ugi_pkg::RST_BUF_CONTROL[
                ugi_pkg::BIT_EP_GLOBAL_IRQ_ENABLE]}};
        else
            endpoint_global_irq_enable <= (endpoint_global_irq_enable
                & ~gie_write) | (gie_write
                & {NUM_EP{sfr_wdata[ugi_pkg::BIT_EP_GLOBAL_IRQ_ENABLE]}});
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            requests_prev <= '0;
            sfr_rdata <= 8'h00;
            usb_irq <= 1'b0;
        end
        else
        begin
            requests_prev <= endpoint_requests;
            sfr_rdata <= next_rdata;
            usb_irq <= next_usb_irq;
        end
    end

    // checks
    property p_rv_set;
        @(posedge sys_clk) disable iff (rst)
        request_value_event |=> request_value_irq_flag;
    endproperty
    a_rv_set: assert property (p_rv_set)
        else $error("request-value flag not set");
    property p_rv_hold;
        @(posedge sys_clk) disable iff (rst)
        request_value_irq_flag && !rv_clear |=> request_value_irq_flag;
    endproperty
    a_rv_hold: assert property (p_rv_hold)
        else $error("request-value flag cleared without a zero write");
    property p_rv_one_ignored;
        @(posedge sys_clk) disable iff (rst)
        !request_value_irq_flag && !request_value_event
            |=> !request_value_irq_flag;
    endproperty
    a_rv_one_ignored: assert property (p_rv_one_ignored)
        else $error("request-value flag set without an event");
    property p_rv_irq_cause;
        @(posedge sys_clk) disable iff (rst)
        usb_irq |-> $past(ep_irq_path) || $past(request_value_irq_flag
            && request_value_irq_enable && cpu_master_irq_enable);
    endproperty
    a_rv_irq_cause: assert property (p_rv_irq_cause)
        else $error("interrupt without an enabled cause");
    property p_reserved_zero;
        @(posedge sys_clk) disable iff (rst)
        $past(sfr_addr) == ugi_pkg::ADDR_GLOBAL_FLAGS |->
            sfr_rdata[ugi_pkg::BIT_RESERVED_HI:ugi_pkg::BIT_RESERVED_LO]
            == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");
    property p_pending_view;
        @(posedge sys_clk) disable iff (rst)
        $past(sfr_addr) == ugi_pkg::ADDR_GLOBAL_FLAGS |->
            sfr_rdata[NUM_EP-1:0] == $past(endpoint_pending);
    endproperty
    a_pending_view: assert property (p_pending_view)
        else $error("pending bits not shown");
    property p_ep_irq;
        @(posedge sys_clk) disable iff (rst)
        |(endpoint_pending & endpoint_global_irq_enable)
            && cpu_master_irq_enable && usb_endpoint_cpu_irq_enable
            |=> usb_irq;
    endproperty
    a_ep_irq: assert property (p_ep_irq)
        else $error("enabled pending endpoint raised no interrupt");
    property p_cpu_gate;
        @(posedge sys_clk) disable iff (rst)
        !cpu_master_irq_enable |=> !usb_irq;
    endproperty
    a_cpu_gate: assert property (p_cpu_gate)
        else $error("interrupt with master enable off");
    property p_device_set_guard;
        @(posedge sys_clk) disable iff (rst)
        sfr_wr && sfr_addr == ugi_pkg::ADDR_BUF_CONTROL && device_set_selected
            |=> $stable(endpoint_global_irq_enable);
    endproperty
    a_device_set_guard: assert property (p_device_set_guard)
        else $error("endpoint enable changed with device set selected");

    property p_ep_set;
        @(posedge sys_clk) disable iff (rst)
        ep_set != '0 |=> (endpoint_pending & $past(ep_set)) == $past(ep_set);
    endproperty
    a_ep_set: assert property (p_ep_set)
        else $error("endpoint request did not set pending");

    property p_ep_clear;
        @(posedge sys_clk) disable iff (rst)
        (ep_read_clear & ~ep_set) != '0 |=>
            (endpoint_pending & $past(ep_read_clear & ~ep_set)) == '0;
    endproperty
    a_ep_clear: assert property (p_ep_clear)
        else $error("pending not cleared by request register read");

    c_rv_irq: cover property (@(posedge sys_clk) disable iff (rst)
        request_value_event ##1 request_value_irq_flag ##1 usb_irq);
    c_ep_cycle: cover property (@(posedge sys_clk) disable iff (rst)
        ep_set != '0 ##[1:20] ep_read_clear != '0);
    c_set_beats_clear: cover property (@(posedge sys_clk) disable iff (rst)
        (ep_set & ep_read_clear) != '0);
endmodule : ugi_global_irq

// ==== hdl/ugi_pkg.sv ====
package ugi_pkg;
    localparam int NUM_EP = 5;
    localparam int REQS_PER_EP = 8;
    localparam logic [7:0] ADDR_BUF_CONTROL = 8'hC1;
    localparam logic [7:0] ADDR_EP_IRQ_REQ = 8'hC4;
    localparam logic [7:0] ADDR_SET_SELECT = 8'hD2;
    localparam logic [7:0] ADDR_GLOBAL_FLAGS = 8'hD6;
    localparam logic [7:0] ADDR_POWER_DOWN = 8'hE6;
    localparam logic [7:0] DEVICE_SET_VALUE = 8'h80;
    localparam logic [2:0] LAST_EP_INDEX = 3'h4;
    localparam int BIT_REQ_VALUE_FLAG = 7;
    localparam int BIT_RESERVED_HI = 6;
    localparam int BIT_RESERVED_LO = 5;
    localparam int BIT_EP_GLOBAL_IRQ_ENABLE = 4;
    localparam int BIT_REQ_VALUE_ENABLE = 0;
    localparam int BIT_SET_KIND = 7;
    localparam logic [7:0] RST_SET_SELECT = 8'h00;
    localparam logic [7:0] RST_GLOBAL_FLAGS = 8'h00;
    localparam logic [7:0] RST_BUF_CONTROL = 8'h00;
    localparam logic RST_REQ_VALUE_ENABLE = 1'h0;
endpackage : ugi_pkg

// ==== hdl/ugi_sticky_flags.sv ====
`timescale 1ns/1ns
module ugi_sticky_flags
#(
    parameter int WIDTH = 1
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;

    // set wins over a clear in the same cycle
    assign next_flags = set | (flags & ~clr);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            flags <= '0;
        else
            flags <= next_flags;
    end
endmodule : ugi_sticky_flags

// ==== testbench/ugi_far_side.sv ====
`timescale 1ns/1ns
module ugi_far_side
(
    input wire logic sys_clk,
    output logic [39:0] endpoint_requests,
    output logic request_value_event,
    output logic cpu_master_irq_enable,
    output logic usb_endpoint_cpu_irq_enable
);
    initial
    begin
        endpoint_requests = 40'h0;
        request_value_event = 1'h0;
        cpu_master_irq_enable = 1'h0;
        usb_endpoint_cpu_irq_enable = 1'h0;
    end

    // endpoint request level, held until told otherwise
    task automatic set_request(input int idx, input logic lvl);
        @(posedge sys_clk);
        endpoint_requests[idx] <= lvl;
    endtask : set_request

    // one-cycle host request carrying a value
    task automatic value_request();
        @(posedge sys_clk);
        request_value_event <= 1'h1;
        @(posedge sys_clk);
        request_value_event <= 1'h0;
    endtask : value_request

    task automatic set_enables(input logic ea, input logic eu);
        @(posedge sys_clk);
        cpu_master_irq_enable <= ea;
        usb_endpoint_cpu_irq_enable <= eu;
    endtask : set_enables
endmodule : ugi_far_side

// ==== testbench/ugi_global_irq_bench.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("mismatch %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module ugi_global_irq_bench;
    localparam logic [7:0] A_GF = ugi_pkg::ADDR_GLOBAL_FLAGS;
    localparam logic [7:0] A_SEL = ugi_pkg::ADDR_SET_SELECT;
    localparam logic [7:0] A_REQ = ugi_pkg::ADDR_EP_IRQ_REQ;
    localparam logic [7:0] A_BC = ugi_pkg::ADDR_BUF_CONTROL;
    localparam logic [7:0] A_PD = ugi_pkg::ADDR_POWER_DOWN;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'h0;
    logic sfr_rd = 1'h0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [39:0] endpoint_requests;
    logic request_value_event;
    logic ea;
    logic eu;
    logic usb_irq;
    logic rd_seen = 1'h0;
    logic [7:0] exp_q[$];
    logic [7:0] exp_rd;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 23569;
    int b;

    ugi_global_irq i_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .cpu_master_irq_enable(ea),
        .usb_endpoint_cpu_irq_enable(eu),
        .endpoint_requests(endpoint_requests),
        .request_value_event(request_value_event), .usb_irq(usb_irq));
    ugi_far_side i_far (.sys_clk(sys_clk),
        .endpoint_requests(endpoint_requests),
        .request_value_event(request_value_event),
        .cpu_master_irq_enable(ea), .usb_endpoint_cpu_irq_enable(eu));

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'h1;
        @(posedge sys_clk);
        sfr_wr <= 1'h0;
    endtask : sfr_write

    // expected read data noted here, checked by the watcher
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'h1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        sfr_rd <= 1'h0;
    endtask : sfr_read

    task automatic irq_is(input logic e);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(usb_irq, e)
    endtask : irq_is

    always @(posedge sys_clk) rd_seen <= sfr_rd;
    always @(negedge sys_clk)
    begin
        if (rd_seen)
        begin
            exp_rd = exp_q.pop_front();
            `CHK(sfr_rdata, exp_rd)
        end
    end

    initial
    begin
        #200000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        sfr_read(A_GF, 8'h00);
        for (int n = 0; n < 5; n++)
        begin
            b = n * 8 + ($unsigned($random(seed)) % 8);
            sfr_write(A_SEL, 8'(n));
            i_far.set_request(b, 1'h1);
            sfr_read(A_GF, 8'h01 << n);
            sfr_read(A_REQ, 8'h01 << (b % 8));
            sfr_read(A_GF, 8'h00);
            i_far.set_request(b, 1'h0);
        end
        sfr_write(A_SEL, 8'h02);
        i_far.set_request(17, 1'h1);
        sfr_write(A_BC, 8'h10);
        sfr_read(A_BC, 8'h10);
        for (int k = 0; k < 4; k++)
        begin
            i_far.set_enables(k[1], k[0]);
            irq_is(k == 3);
        end
        sfr_write(A_SEL, 8'h80);
        sfr_read(A_BC, 8'h00);
        sfr_write(A_SEL, 8'h02);
        sfr_read(A_BC, 8'h10);
        sfr_write(A_BC, 8'h00);
        irq_is(1'h0);
        sfr_read(A_REQ, 8'h02);
        i_far.set_request(17, 1'h0);
        sfr_read(8'hC7, 8'h00);
        i_far.set_enables(1'h1, 1'h0);
        i_far.value_request();
        sfr_read(A_GF, 8'h80);
        sfr_write(A_GF, 8'h80);
        sfr_read(A_GF, 8'h80);
        irq_is(1'h0);
        sfr_write(A_PD, 8'h01);
        irq_is(1'h1);
        sfr_write(A_PD, 8'h00);
        irq_is(1'h0);
        sfr_write(A_GF, 8'h00);
        sfr_read(A_GF, 8'h00);
        fork
            i_far.value_request();
            sfr_write(A_GF, 8'h00);
        join
        sfr_read(A_GF, 8'h80);
        sfr_write(A_GF, 8'h00);
        sfr_read(A_GF, 8'h00);
        repeat (2) @(posedge sys_clk);
        end_of_test();
    end
endmodule : ugi_global_irq_bench
